/* File: rtl/sml_host_link.sv */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [RQ1] Each message: size pair, turn-around wait, then header pair with payload.
// [RQ2] Sender puts payload size in low byte of its size request.
// [RQ3] Receiver returns free buffer size in low byte of size ack.
// [RQ4] Size too large: wait turn-around, then request again.
// [RQ5] After size pair and wait, header follows; payload follows header, zero padded.
// [RQ6] After payload, wait one turn-around before any further exchange.
// [RQ7] Turn-around of 200 us between every step of an exchange.
// [RQ8] Clock, select and data out undriven whenever host request low.
// [RQ9] Raise host request and select high; no clocking until node ready.
// [RQ10] Node request high makes host start a transaction.
// [RQ11] With ready high, select low, host toggles clock and data out.
// [RQ12] Host drops its request when idle and no node request pending.
// [RQ13] Node drops its request when it has nothing more to send.
// [RQ14] Node drops ready after host request falls.
// [RQ15] Size pair is followed by the matching header pair.
// [RQ16] Clock idles low; sample on rising edge, change on falling edge.
// [RQ17] Command starts with direction code and two-byte length code.
// [RQ18] Host size opcode 1001, host header opcode 1010.
// [RQ19] Header words carry fixed value one after the opcode.
// [RQ20] Payload little endian, least significant byte first.
// [RQ21] Header payloads end with the fixed 32-bit trailing pattern.
// [RQ22] Payload travels only with the sending side's header word.
// [RQ23] Node size opcode 1011, node header opcode 1100.
// [RQ24] Payload opens with byte count including itself and trailer, then type.
// [RQ25] Arbitration with node completes before any other bus traffic.
// [RQ26] Command words shifted most significant bit first.
module sml_host_link #(
  parameter int unsigned TA_CYCLES = sml_pkg::TA_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire sml_pkg::sml_axi_req_s I_AXI,
  output var sml_pkg::sml_axi_rsp_s O_AXI,
  input wire logic I_MISO,
  input wire logic I_NODE_REQUEST,
  input wire logic I_NODE_READY,
  output var sml_pkg::sml_pins_s O_PINS
);
  import sml_pkg::*;

  // Pin synchronisers: index 0 miso, 1 node_request, 2 node_ready
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic miso_s;
  logic node_req_s;
  logic node_rdy_s;

  sml_axi_rsp_s axi_q;
  sml_pins_s pins_q;
  sml_state_e state_q;
  sml_step_e step_q;

  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rd_data;
  logic rd_hit;

  logic tx_req_q;
  logic raw_req_q;
  logic arb_done_q;
  logic rx_en_q;
  logic tx_done_q;
  logic rx_valid_q;
  logic raw_done_q;
  logic [7:0] tx_len_q;
  logic [7:0] rx_buf_q;
  logic [15:0] raw_tx_q;
  logic [15:0] raw_rx_q;
  logic [7:0] tx_mem [MEM_BYTES];
  logic [7:0] rx_mem [MEM_BYTES];

  logic take_tx;
  logic take_raw;
  logic take_rx;
  logic evt_tx_q;
  logic evt_rx_q;
  logic evt_raw_q;
  logic more_q;
  logic trailer_ok_q;
  logic [7:0] ack_q;
  logic [7:0] rx_len_q;
  logic [15:0] ta_q;
  logic [2:0] div_q;
  logic [11:0] bit_q;
  logic [11:0] nbits_q;
  logic [11:0] bit_n;
  logic [7:0] byte_idx_q;
  logic [7:0] rx_idx_q;
  logic [15:0] tx_sh_q;
  logic [15:0] rx_sh_q;
  logic [31:0] tail_q;
  logic [15:0] frame_cmd;
  logic [7:0] frame_bytes;
  logic [7:0] next_byte;
  logic [7:0] announced;
  logic rx_store;

  assign O_AXI = axi_q;
  assign O_PINS = pins_q;
  assign miso_s = sync2_q[0];
  assign node_req_s = sync2_q[1];
  assign node_rdy_s = sync2_q[2];

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {I_NODE_READY, I_NODE_REQUEST, I_MISO};
      sync2_q <= sync1_q;
    end
  end

  // AXI4-Lite slave: address and data taken in either order
  assign wr_fire = aw_got_q && w_got_q && !axi_q.bvalid;
  assign rd_fire = I_AXI.arvalid && axi_q.arready;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      axi_q <= '0;
      axi_q.awready <= 1'b1;
      axi_q.wready <= 1'b1;
      axi_q.arready <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (I_AXI.awvalid && axi_q.awready) begin
        axi_q.awready <= 1'b0;
        aw_got_q <= 1'b1;
        awaddr_q <= I_AXI.awaddr;
      end
      if (I_AXI.wvalid && axi_q.wready) begin
        axi_q.wready <= 1'b0;
        w_got_q <= 1'b1;
        wdata_q <= I_AXI.wdata;
        wstrb_q <= I_AXI.wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        axi_q.bvalid <= 1'b1;
        axi_q.bresp <= (awaddr_q[7:6] == REGION_TX
                        || awaddr_q <= OFF_RAW) ? RESP_OKAY : RESP_SLVERR;
      end
      if (axi_q.bvalid && I_AXI.bready) begin
        axi_q.bvalid <= 1'b0;
        axi_q.awready <= 1'b1;
        axi_q.wready <= 1'b1;
      end
      if (rd_fire) begin
        axi_q.arready <= 1'b0;
        axi_q.rvalid <= 1'b1;
        axi_q.rdata <= rd_data;
        axi_q.rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (axi_q.rvalid && I_AXI.rready) begin
        axi_q.rvalid <= 1'b0;
        axi_q.arready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (I_AXI.araddr[7:6])
      REGION_TX: begin
        for (int b = 0; b < 4; b++) begin
          rd_data[8*b +: 8] = tx_mem[{I_AXI.araddr[5:2], 2'(b)}];
        end
      end
      REGION_RX: begin
        for (int b = 0; b < 4; b++) begin
          rd_data[8*b +: 8] = rx_mem[{I_AXI.araddr[5:2], 2'(b)}];
        end
      end
      default: begin
        case (I_AXI.araddr)
          OFF_CTRL: begin
            rd_data[CTRL_START_TX] = tx_req_q;
            rd_data[CTRL_ARB_DONE] = arb_done_q;
            rd_data[CTRL_RAW_START] = raw_req_q;
            rd_data[CTRL_RX_EN] = rx_en_q;
          end
          OFF_STATUS: begin
            rd_data[ST_BUSY] = (state_q != ST_IDLE);
            rd_data[ST_TX_DONE] = tx_done_q;
            rd_data[ST_RX_VALID] = rx_valid_q;
            rd_data[ST_TRAILER_OK] = trailer_ok_q;
            rd_data[ST_RAW_DONE] = raw_done_q;
            rd_data[ST_ACK_LSB +: 8] = ack_q;
            rd_data[ST_RXLEN_LSB +: 8] = rx_len_q;
          end
          OFF_TX_LEN: rd_data[7:0] = tx_len_q;
          OFF_RX_BUF: rd_data[7:0] = rx_buf_q;
          OFF_RAW: rd_data = {raw_rx_q, raw_tx_q};
          default: rd_hit = 1'b0;
        endcase
      end
    endcase
  end

  // Control and status; a hardware set wins over a clear written that cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      tx_req_q <= 1'b0;
      raw_req_q <= 1'b0;
      arb_done_q <= 1'b0;
      rx_en_q <= 1'b0;
      tx_done_q <= 1'b0;
      rx_valid_q <= 1'b0;
      raw_done_q <= 1'b0;
      tx_len_q <= TX_LEN_RST;
      rx_buf_q <= RX_BUF_RST;
      raw_tx_q <= 16'h0000;
    end else begin
      tx_req_q <= tx_req_q && !take_tx;
      raw_req_q <= raw_req_q && !take_raw;
      if (wr_fire && wstrb_q[0] && awaddr_q == OFF_CTRL) begin
        tx_req_q <= (tx_req_q && !take_tx) || wdata_q[CTRL_START_TX];
        raw_req_q <= (raw_req_q && !take_raw) || wdata_q[CTRL_RAW_START];
        arb_done_q <= wdata_q[CTRL_ARB_DONE];
        rx_en_q <= wdata_q[CTRL_RX_EN];
      end
      if (wr_fire && wstrb_q[0] && awaddr_q == OFF_STATUS) begin
        tx_done_q <= evt_tx_q || (tx_done_q && !wdata_q[ST_TX_DONE]);
        rx_valid_q <= evt_rx_q || (rx_valid_q && !wdata_q[ST_RX_VALID]);
        raw_done_q <= evt_raw_q || (raw_done_q && !wdata_q[ST_RAW_DONE]);
      end else begin
        tx_done_q <= evt_tx_q || tx_done_q;
        rx_valid_q <= evt_rx_q || rx_valid_q;
        raw_done_q <= evt_raw_q || raw_done_q;
      end
      if (wr_fire && wstrb_q[0] && awaddr_q == OFF_TX_LEN) begin
        tx_len_q <= wdata_q[7:0];
      end
      if (wr_fire && wstrb_q[0] && awaddr_q == OFF_RX_BUF) begin
        rx_buf_q <= wdata_q[7:0];
      end
      if (wr_fire && awaddr_q == OFF_RAW) begin
        if (wstrb_q[0]) raw_tx_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) raw_tx_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    for (int b = 0; b < 4; b++) begin
      if (wr_fire && wstrb_q[b] && awaddr_q[7:6] == REGION_TX) begin
        tx_mem[{awaddr_q[5:2], 2'(b)}] <= wdata_q[8*b +: 8];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (rx_store) begin
      rx_mem[rx_idx_q[5:0]] <= rx_sh_q[7:0];
    end
  end

  // Job selection; host and node messages only after software marks arbitration done, the raw word at any time
  always_comb begin
    take_tx = 1'b0;
    take_raw = 1'b0;
    take_rx = 1'b0;
    // Stale ready must clear after a drop
    if (state_q == ST_IDLE && (pins_q.host_request || !node_rdy_s)) begin
      if (tx_req_q && arb_done_q) begin // [RQ25]
        take_tx = 1'b1;
      end else if (raw_req_q) begin
        take_raw = 1'b1;
      end else if (node_req_s && rx_en_q && arb_done_q) begin // [RQ10]
        take_rx = 1'b1;
      end
    end
  end

  assign announced = 8'(tx_len_q + TRAILER_BYTES); // [RQ24]

  // Command word, direction code first [RQ26]
  always_comb begin
    frame_cmd = raw_tx_q;
    frame_bytes = 8'h00;
    case (step_q)
      STEP_HOST_SIZE: frame_cmd = {DIR_H2N, LEN_TWO, OP_HOST_SIZE,
                                   announced}; // [RQ2] [RQ17] [RQ18]
      STEP_HOST_HDR: begin
        frame_cmd = {DIR_H2N, LEN_TWO, OP_HOST_HDR, HDR_FIXED}; // [RQ19]
        frame_bytes = announced; // [RQ22]
      end
      STEP_NODE_SIZE: frame_cmd = {DIR_H2N, LEN_TWO, OP_NODE_SIZE,
                                   rx_buf_q}; // [RQ3] [RQ23]
      STEP_NODE_HDR: begin
        frame_cmd = {DIR_H2N, LEN_TWO, OP_NODE_HDR, HDR_FIXED}; // [RQ23]
        frame_bytes = rx_len_q;
      end
      default: frame_cmd = raw_tx_q;
    endcase
  end

  // Payload bytes: data, then trailer low byte first, then zero pad
  always_comb begin
    next_byte = 8'h00; // [RQ5]
    if (step_q == STEP_HOST_HDR) begin
      if (byte_idx_q < tx_len_q) begin
        next_byte = tx_mem[byte_idx_q[5:0]];
      end else if (byte_idx_q < announced) begin // [RQ20] [RQ21]
        next_byte = TRAILER[8*(2'(byte_idx_q[1:0] - tx_len_q[1:0])) +: 8];
      end
    end
  end

  assign bit_n = bit_q + 12'h001;
  assign rx_store = state_q == ST_FRAME && div_q == SCK_FALL
                    && step_q == STEP_NODE_HDR && bit_n > CMD_BITS
                    && bit_n[2:0] == 3'h0;

  // Serial engine
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      state_q <= ST_IDLE;
      step_q <= STEP_HOST_SIZE;
      pins_q <= '0;
      pins_q.cs_n <= 1'b1;
      evt_tx_q <= 1'b0;
      evt_rx_q <= 1'b0;
      evt_raw_q <= 1'b0;
      more_q <= 1'b0;
      trailer_ok_q <= 1'b0;
      ack_q <= 8'h00;
      rx_len_q <= 8'h00;
      raw_rx_q <= 16'h0000;
      ta_q <= 16'h0000;
      div_q <= 3'h0;
      bit_q <= 12'h000;
      nbits_q <= 12'h000;
      byte_idx_q <= 8'h00;
      rx_idx_q <= 8'h00;
      tx_sh_q <= 16'h0000;
      rx_sh_q <= 16'h0000;
      tail_q <= 32'h0000_0000;
    end else begin
      evt_tx_q <= 1'b0;
      evt_rx_q <= 1'b0;
      evt_raw_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take_tx || take_raw || take_rx) begin
            step_q <= take_tx ? STEP_HOST_SIZE
                    : (take_raw ? STEP_RAW : STEP_NODE_SIZE); // [RQ1]
            pins_q.host_request <= 1'b1; // [RQ9]
            pins_q.cs_n <= 1'b1;
            pins_q.sclk <= 1'b0;
            pins_q.sclk_oe <= 1'b1;
            pins_q.cs_oe <= 1'b1;
            pins_q.mosi_oe <= 1'b1;
            state_q <= ST_WAKE;
          end else begin
            pins_q.host_request <= 1'b0; // [RQ12]
            pins_q.sclk_oe <= 1'b0; // [RQ8]
            pins_q.cs_oe <= 1'b0;
            pins_q.mosi_oe <= 1'b0;
          end
        end
        ST_WAKE, ST_GAP: begin
          ta_q <= ta_q + 16'h0001;
          // Wait for ready before the first clock edge [RQ9] [RQ11]
          if ((state_q == ST_WAKE && node_rdy_s)
              || (state_q == ST_GAP
                  && ta_q == 16'(TA_CYCLES - 1))) begin // [RQ6] [RQ7]
            ta_q <= 16'h0000;
            if (state_q == ST_GAP && !more_q) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_FRAME;
              pins_q.cs_n <= 1'b0; // [RQ11]
              pins_q.mosi <= frame_cmd[15];
              tx_sh_q <= frame_cmd;
              div_q <= 3'h0;
              bit_q <= 12'h000;
              byte_idx_q <= 8'h00;
              rx_idx_q <= 8'h00;
              nbits_q <= {1'b0, frame_bytes, 3'h0} + CMD_BITS;
            end
          end
        end
        ST_FRAME: begin
          div_q <= div_q + 3'h1;
          if (div_q == SCK_RISE) begin
            pins_q.sclk <= 1'b1; // [RQ16]
            rx_sh_q <= {rx_sh_q[14:0], miso_s};
          end
          if (div_q == SCK_FALL) begin
            pins_q.sclk <= 1'b0; // [RQ16]
            div_q <= 3'h0;
            bit_q <= bit_n;
            if (rx_store) begin
              rx_idx_q <= rx_idx_q + 8'h01;
              tail_q <= {rx_sh_q[7:0], tail_q[31:8]};
            end
            if (bit_n > CMD_BITS - 12'h001 && bit_n[2:0] == 3'h0) begin
              tx_sh_q <= {next_byte, 8'h00};
              pins_q.mosi <= next_byte[7];
              byte_idx_q <= byte_idx_q + 8'h01;
            end else begin
              tx_sh_q <= {tx_sh_q[14:0], 1'b0};
              pins_q.mosi <= tx_sh_q[14];
            end
            if (bit_n == CMD_BITS) begin
              ack_q <= rx_sh_q[7:0];
            end
            if (bit_n == nbits_q) begin
              pins_q.cs_n <= 1'b1;
              pins_q.mosi <= 1'b0;
              state_q <= ST_GAP;
              more_q <= 1'b0;
              case (step_q)
                STEP_HOST_SIZE: begin
                  more_q <= 1'b1;
                  if (rx_sh_q[7:0] >= announced) begin
                    step_q <= STEP_HOST_HDR; // [RQ15]
                  end // [RQ4]
                end
                STEP_NODE_SIZE: begin
                  more_q <= 1'b1;
                  step_q <= STEP_NODE_HDR; // [RQ15]
                  rx_len_q <= (rx_sh_q[7:0] > rx_buf_q) ? rx_buf_q
                              : rx_sh_q[7:0]; // [RQ13]
                end
                STEP_HOST_HDR: evt_tx_q <= 1'b1;
                STEP_NODE_HDR: begin
                  evt_rx_q <= 1'b1;
                  trailer_ok_q <= {rx_sh_q[7:0], tail_q[31:8]}
                                  == TRAILER; // [RQ21]
                end
                default: begin
                  evt_raw_q <= 1'b1;
                  raw_rx_q <= rx_sh_q;
                end
              endcase
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule : sml_host_link

`default_nettype wire

/* File: rtl/sml_pkg.sv */
package sml_pkg;

  // Timing
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned TA_US = 200;
  localparam int unsigned TA_CYC = TA_US * CLK_MHZ;
  localparam int unsigned SCK_HALF = 4;
  localparam logic [2:0] SCK_RISE = 3'(SCK_HALF - 1);
  localparam logic [2:0] SCK_FALL = 3'(2 * SCK_HALF - 1);

  // Register map, byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TX_LEN = 8'h08;
  localparam logic [7:0] OFF_RX_BUF = 8'h0c;
  localparam logic [7:0] OFF_RAW = 8'h10;
  localparam logic [1:0] REGION_TX = 2'h1;
  localparam logic [1:0] REGION_RX = 2'h2;
  localparam int unsigned MEM_BYTES = 64;

  // Field positions
  localparam int unsigned CTRL_START_TX = 0;
  localparam int unsigned CTRL_ARB_DONE = 1;
  localparam int unsigned CTRL_RAW_START = 2;
  localparam int unsigned CTRL_RX_EN = 3;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_TX_DONE = 1;
  localparam int unsigned ST_RX_VALID = 2;
  localparam int unsigned ST_TRAILER_OK = 3;
  localparam int unsigned ST_RAW_DONE = 4;
  localparam int unsigned ST_ACK_LSB = 8;
  localparam int unsigned ST_RXLEN_LSB = 16;

  // Reset values
  localparam logic [7:0] TX_LEN_RST = 8'h00;
  localparam logic [7:0] RX_BUF_RST = 8'h40;

  // Command word fields
  localparam logic [1:0] DIR_H2N = 2'h2;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [3:0] OP_HOST_SIZE = 4'h9;
  localparam logic [3:0] OP_HOST_HDR = 4'ha;
  localparam logic [3:0] OP_NODE_SIZE = 4'hb;
  localparam logic [3:0] OP_NODE_HDR = 4'hc;
  localparam logic [7:0] HDR_FIXED = 8'h01;
  localparam logic [31:0] TRAILER = 32'hf0f0a5a5;
  localparam logic [7:0] TRAILER_BYTES = 8'h04;
  localparam logic [11:0] CMD_BITS = 12'h010;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE = 3'b001,
    ST_FRAME = 3'b011,
    ST_GAP = 3'b010
  } sml_state_e;

  typedef enum logic [2:0] {
    STEP_HOST_SIZE = 3'h0,
    STEP_HOST_HDR = 3'h1,
    STEP_NODE_SIZE = 3'h2,
    STEP_NODE_HDR = 3'h3,
    STEP_RAW = 3'h4
  } sml_step_e;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } sml_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sml_axi_rsp_s;

  typedef struct packed {
    logic host_request;
    logic sclk;
    logic sclk_oe;
    logic cs_n;
    logic cs_oe;
    logic mosi;
    logic mosi_oe;
  } sml_pins_s;

endpackage : sml_pkg

/* File: tb/sml_host_link_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module sml_mon #(
  parameter int unsigned TA_CYCLES = 20
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire sml_pkg::sml_axi_req_s I_AXI,
  input wire sml_pkg::sml_axi_rsp_s O_AXI,
  input wire logic I_MISO,
  input wire logic I_NODE_REQUEST,
  input wire logic I_NODE_READY,
  input wire sml_pkg::sml_pins_s O_PINS
);
  import sml_pkg::*;
  logic [15:0] gap_q;
  logic [9:0] bit_q;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RESET);
  // Saturates so the first frame of a session is not judged
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET || !O_PINS.host_request) gap_q <= 16'hffff;
    else if (!O_PINS.cs_n) gap_q <= 16'h0;
    else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h1;
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET || O_PINS.cs_n) bit_q <= 10'h0;
    else if ($rose(O_PINS.sclk)) bit_q <= bit_q + 10'h1;
  end
  sequence wr_taken;
    I_AXI.awvalid && O_AXI.awready && I_AXI.wvalid && O_AXI.wready;
  endsequence
  sequence rd_taken;
    I_AXI.arvalid && O_AXI.arready;
  endsequence
  sequence high_phase;
    (O_PINS.sclk) [*4] ##1 !O_PINS.sclk;
  endsequence
  sequence low_phase;
    (!O_PINS.sclk) [*4] ##1 O_PINS.sclk;
  endsequence
  wr_resp_a: assert property (wr_taken |-> ##2 O_AXI.bvalid)
    else $error("write response missing");
  rd_resp_a: assert property (rd_taken |=> O_AXI.rvalid)
    else $error("read response missing");
  rd_hold_a: assert property (O_AXI.rvalid && !I_AXI.rready
    |=> O_AXI.rvalid && $stable(O_AXI.rdata))
    else $error("read data dropped early");
  oe_release_a: assert property (!O_PINS.host_request
    |-> !O_PINS.sclk_oe && !O_PINS.cs_oe && !O_PINS.mosi_oe)
    else $error("pin driven while host request low");
  clk_idle_a: assert property (O_PINS.cs_n |-> !O_PINS.sclk)
    else $error("serial clock high outside frame");
  clk_high_a: assert property ($rose(O_PINS.sclk) |-> high_phase)
    else $error("serial clock high phase wrong");
  clk_low_a: assert property ($fell(O_PINS.sclk) && !O_PINS.cs_n
    |-> low_phase)
    else $error("serial clock low phase wrong");
  mosi_fall_a: assert property (!O_PINS.cs_n && !$past(O_PINS.cs_n)
    && $changed(O_PINS.mosi) |-> $fell(O_PINS.sclk))
    else $error("data out changed off falling edge");
  ready_first_a: assert property ($fell(O_PINS.cs_n)
    |-> $past(I_NODE_READY, 2))
    else $error("select before node ready");
  select_hold_a: assert property (!O_PINS.cs_n
    |-> O_PINS.host_request && O_PINS.cs_oe && O_PINS.sclk_oe)
    else $error("select low without drive");
  wake_high_a: assert property ($rose(O_PINS.host_request)
    |-> O_PINS.cs_n && O_PINS.cs_oe)
    else $error("select not high at wake");
  gap_wait_a: assert property ($fell(O_PINS.cs_n)
    |-> gap_q >= 16'(TA_CYCLES - 1))
    else $error("turn-around gap too short");
  word_bits_a: assert property ($rose(O_PINS.cs_n)
    |-> bit_q >= 10'h010 && bit_q[2:0] == 3'h0)
    else $error("frame not whole bytes");
endmodule : sml_mon
bind sml_host_link sml_mon #(.TA_CYCLES(TA_CYCLES)) mon_u (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_AXI(I_AXI),
  .O_AXI(O_AXI), .I_MISO(I_MISO), .I_NODE_REQUEST(I_NODE_REQUEST),
  .I_NODE_READY(I_NODE_READY), .O_PINS(O_PINS));
`default_nettype wire

/* File: tb/sml_host_link_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module sml_host_link_tb;
  import sml_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sml_axi_req_s axi = '0;
  sml_axi_rsp_s rsp;
  sml_pins_s pins;
  logic miso, nreq, nrdy;
  logic send = 1'b0;
  logic slow = 1'b0;
  logic [7:0] bsz = 8'h06;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] tx_exp [8] = '{8'h08, 8'h00, 8'h03, 8'h04,
                             8'ha5, 8'ha5, 8'hf0, 8'hf0};
  int bad_count = 0;
  int tests_run = 0;
  int n0;
  always #12.5 clk = ~clk;
  // Short turn-around keeps the run small
  sml_host_link #(.TA_CYCLES(40)) dut_u (.I_CLK_SYS(clk), .I_RESET(rst),
    .I_AXI(axi), .O_AXI(rsp), .I_MISO(miso), .I_NODE_REQUEST(nreq),
    .I_NODE_READY(nrdy), .O_PINS(pins));
  sml_node_model node_u (.i_clk(clk), .i_reset(rst), .i_pins(pins),
    .i_send(send), .i_slow(slow), .i_buf(bsz), .i_len(8'h08),
    .o_miso(miso), .o_node_request(nreq), .o_node_ready(nrdy));
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit done;
    done = 0;
    @(posedge clk);
    axi.awvalid <= 1'b1;
    axi.awaddr <= a;
    axi.wvalid <= 1'b1;
    axi.wdata <= v;
    axi.wstrb <= 4'hf;
    axi.bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (axi.awvalid && rsp.awready) axi.awvalid <= 1'b0;
      if (axi.wvalid && rsp.wready) axi.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        done = 1;
        r = rsp.bresp;
      end
    end
    axi.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bit done;
    done = 0;
    @(posedge clk);
    axi.arvalid <= 1'b1;
    axi.araddr <= a;
    axi.rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (axi.arvalid && rsp.arready) axi.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        done = 1;
        d = rsp.rdata;
        r = rsp.rresp;
      end
    end
    axi.rready <= 1'b0;
  endtask : rd
  task automatic wait_st(input int b);
    d = 32'h0;
    while (d[b] !== 1'b1) rd(OFF_STATUS);
  endtask : wait_st
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    #1500000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_TX_LEN);
    chk("tx_len", 32'h0, d);
    rd(OFF_RX_BUF);
    chk("rx_buf", 32'h40, d);
    wr(8'h20, 32'h1);
    chk("wr_unmapped", RESP_SLVERR, r);
    wr(8'h80, 32'h1);
    chk("wr_readonly", RESP_SLVERR, r);
    rd(8'h20);
    chk("rd_unmapped", RESP_SLVERR, r);
    // Software arbitration word, sent before the arbitration gate opens
    wr(OFF_RAW, 32'h5a3c);
    wr(OFF_CTRL, 32'h4);
    wait_st(ST_RAW_DONE);
    chk("raw_sent", 32'h5a3c, node_u.cmds[0]);
    rd(OFF_RAW);
    chk("raw_seen", {2'h1, LEN_TWO, OP_HOST_SIZE, bsz}, d[31:16]);
    // Host message, refused once for size
    wr(8'h40, 32'h04030008);
    wr(OFF_TX_LEN, 32'h4);
    n0 = node_u.cmds.size();
    wr(OFF_CTRL, 32'h3);
    while (node_u.cmds.size() == n0) @(posedge clk);
    bsz <= 8'h20;
    wait_st(ST_TX_DONE);
    chk("size_cmd", {DIR_H2N, LEN_TWO, OP_HOST_SIZE, 8'h08}, node_u.cmds[n0]);
    chk("size_retry", {DIR_H2N, LEN_TWO, OP_HOST_SIZE, 8'h08}, node_u.cmds[n0 + 1]);
    chk("hdr_cmd", {DIR_H2N, LEN_TWO, OP_HOST_HDR, HDR_FIXED}, node_u.cmds[n0 + 2]);
    chk("tx_count", 32'h8, node_u.pay.size());
    foreach (tx_exp[i]) chk("tx_byte", tx_exp[i], node_u.pay[i]);
    wr(OFF_STATUS, 32'h2);
    rd(OFF_STATUS);
    chk("tx_done_clear", 32'h0, d[ST_TX_DONE]);
    // Node message with a slow ready answer
    slow <= 1'b1;
    wr(OFF_CTRL, 32'ha);
    n0 = node_u.cmds.size();
    while (pins.host_request !== 1'b0) @(posedge clk);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    wait_st(ST_RX_VALID);
    chk("rx_len", 32'h8, d[23:16]);
    chk("trailer_ok", 32'h1, d[ST_TRAILER_OK]);
    chk("rx_size_cmd", {DIR_H2N, LEN_TWO, OP_NODE_SIZE, RX_BUF_RST}, node_u.cmds[n0]);
    chk("rx_hdr_cmd", {DIR_H2N, LEN_TWO, OP_NODE_HDR, HDR_FIXED}, node_u.cmds[n0 + 1]);
    rd(8'h80);
    chk("rx_word0", 32'h63620008, d);
    rd(8'h84);
    chk("rx_word1", TRAILER, d);
    while (pins.host_request !== 1'b0) @(posedge clk);
    chk("pins_off", 32'h0, {pins.sclk_oe, pins.cs_oe, pins.mosi_oe});
    wrap_up();
  end
endmodule : sml_host_link_tb
`default_nettype wire

/* File: tb/sml_node_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sml_node_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire sml_pkg::sml_pins_s i_pins,
  input wire logic i_send,
  input wire logic i_slow,
  input wire logic [7:0] i_buf,
  input wire logic [7:0] i_len,
  output var logic o_miso,
  output var logic o_node_request,
  output var logic o_node_ready
);
  import sml_pkg::*;
  logic hdr_q = 1'b0;
  logic [15:0] sh;
  logic [7:0] bt;
  logic [7:0] wcnt;
  int nb = 0;
  logic [15:0] cmds[$];
  logic [7:0] pay[$];
  initial o_miso = 1'b0;
  initial o_node_request = 1'b0;
  initial o_node_ready = 1'b0;
  function automatic logic obit(input int n);
    logic [15:0] ack;
    logic [7:0] v;
    int b;
    b = (n - 16) / 8;
    ack = {2'h1, LEN_TWO, OP_HOST_SIZE, i_buf};
    if (o_node_request) ack = {2'h1, LEN_TWO, OP_NODE_SIZE, i_len};
    if (hdr_q) begin
      ack = {2'h1, LEN_TWO, OP_HOST_HDR, HDR_FIXED};
      if (o_node_request) ack[11:8] = OP_NODE_HDR;
    end
    v = 8'h60 + 8'(b);
    if (b == 0) v = i_len;
    if (b == 1) v = 8'h00;
    if (b >= int'(i_len) - 4) v = TRAILER[8 * (b - int'(i_len) + 4) +: 8];
    if (!o_node_request || !hdr_q || b >= int'(i_len)) v = 8'h00;
    if (n < 16) return ack[15 - n];
    return v[7 - (n - 16) % 8];
  endfunction : obit
  always @(negedge i_pins.cs_n) begin
    nb = 0;
    pay.delete();
    o_miso = obit(0);
  end
  always @(negedge i_pins.sclk) begin
    if (i_pins.cs_n === 1'b0) o_miso = obit(nb);
  end
  always @(posedge i_pins.sclk) begin
    if (i_pins.cs_n === 1'b0) begin
      if (nb < 16) sh = {sh[14:0], i_pins.mosi};
      else bt = {bt[6:0], i_pins.mosi};
      if (nb >= 16 && nb % 8 == 7) pay.push_back(bt);
      nb++;
    end
  end
  always @(posedge i_pins.cs_n) begin
    // No pull on the line: never leave the last bit standing
    o_miso = ~o_miso;
    if (nb >= 16) begin
      cmds.push_back(sh);
      case (sh[15:8])
        {DIR_H2N, LEN_TWO, OP_HOST_SIZE}: hdr_q = sh[7:0] <= i_buf;
        {DIR_H2N, LEN_TWO, OP_NODE_SIZE}: hdr_q = 1'b1;
        {DIR_H2N, LEN_TWO, OP_HOST_HDR}: hdr_q = 1'b0;
        {DIR_H2N, LEN_TWO, OP_NODE_HDR}: begin
          hdr_q = 1'b0;
          o_node_request = 1'b0;
        end
        default: ;
      endcase
    end
    nb = 0;
  end
  always @(posedge i_clk) begin
    if (i_reset || !i_pins.host_request) begin
      o_node_ready <= 1'b0;
      wcnt <= 8'h0;
    end else if (wcnt >= (i_slow ? 8'h1e : 8'h03)) begin
      o_node_ready <= 1'b1;
    end else begin
      wcnt <= wcnt + 8'h1;
    end
    if (i_send) o_node_request <= 1'b1;
  end
endmodule : sml_node_model
`default_nettype wire
